// ---- common/adc_frame_pkg.sv ----
`default_nettype none
package adc_frame_pkg;
	// ****************************************
	// pin vector layout and widths
	// ****************************************
	localparam int PIN_W = 3;
	localparam int PIN_CS = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_DIN = 2;
	localparam logic [PIN_W-1:0] PIN_RST = 3'h1;
	localparam int CHANNELS = 4;
	localparam int RESULT_W = 8;
	localparam int FIFO_DEPTH = 8;
	// ****************************************
	// frame phases, counted in sclk edges
	// ****************************************
	localparam logic [4:0] FALL_NONE = 5'h00;
	localparam logic [4:0] FALL_FIRST = 5'h01;
	localparam logic [4:0] FALL_HOLD = 5'h04;
	localparam logic [4:0] FALL_LAST = 5'h10;
	localparam logic [3:0] CTRL_BITS = 4'h8;
	localparam logic [3:0] CTRL_LAST_RISE = 4'h7;
	localparam logic [3:0] RESULT_BITS = 4'h8;
	// ****************************************
	// control byte fields and reset values
	// ****************************************
	localparam int CHAN_HI_POS = 4;
	localparam int CHAN_LO_POS = 3;
	localparam logic [1:0] CHAN_RST = 2'h0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	typedef enum logic [1:0]
	{
		MODE_IDLE = 2'b00,
		MODE_TRACK = 2'b01,
		MODE_HOLD = 2'b10
	} mode_t;
endpackage
`default_nettype wire

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);
	// ****************************************
	// two-flop synchroniser, edges from stage two onward
	// ****************************************
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_st_t;

	sync_st_t st_r;
	sync_st_t st_nxt;

	always_comb
	begin
		st_nxt.s1 = i_pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			st_r <= {RST_VAL, RST_VAL, RST_VAL};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign o_level = st_r.s2;
	assign o_rise = st_r.s2 & ~st_r.s3;
	assign o_fall = ~st_r.s2 & st_r.s3;
endmodule
`default_nettype wire

// ---- hdl/result_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	import adc_frame_pkg::*;
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_t;

	fifo_st_t st_r;
	fifo_st_t st_nxt;
	logic push;
	logic pop;

	// ****************************************
	// pointer wrap, any depth allowed
	// ****************************************
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
	endfunction

	assign o_in_ready = (st_r.cnt != FULL_CNT);
	assign o_out_valid = (st_r.cnt != '0);
	assign o_out_data = st_r.mem[st_r.rp];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wp] = i_in_data;
			st_nxt.wp = next_ptr(st_r.wp);
		end
		if (pop)
		begin
			st_nxt.rp = next_ptr(st_r.rp);
		end
		if (push && !pop)
		begin
			st_nxt.cnt = (AW+1)'(st_r.cnt + 1'b1);
		end
		else if (pop && !push)
		begin
			st_nxt.cnt = (AW+1)'(st_r.cnt - 1'b1);
		end
		if (i_flush)
		begin
			st_nxt.wp = '0;
			st_nxt.rp = '0;
			st_nxt.cnt = '0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/adc_frame_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_frame_ctrl (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic [adc_frame_pkg::RESULT_W-1:0] i_code,
	output logic o_dout,
	output logic o_dout_oe_n,
	output logic o_track,
	output logic o_sample,
	output logic [adc_frame_pkg::CHANNELS-1:0] o_mux_sel
);
	import adc_frame_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		mode_t mode;
		logic [4:0] fall_cnt;
		logic [3:0] rise_cnt;
		logic [7:0] ctrl_sh;
		logic [1:0] pend_chan;
		logic [CHANNELS-1:0] mux;
		logic sample;
		logic push_vld;
		logic [RESULT_W-1:0] code;
		logic loaded;
		logic [RESULT_W-1:0] shreg;
		logic [3:0] bits;
		logic dout;
		logic oe_n;
	} frame_st_t;

	frame_st_t st_r;
	frame_st_t st_nxt;
	logic [PIN_W-1:0] pin_lvl;
	logic [PIN_W-1:0] pin_rise;
	logic [PIN_W-1:0] pin_fall;
	logic cs_low;
	logic cs_fall;
	logic sclk_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic din_s;
	logic trk_now;
	logic fifo_in_rdy;
	logic fifo_out_vld;
	logic fifo_pop;
	logic [RESULT_W-1:0] fifo_data;
	logic [7:0] sh_new;

	function automatic logic [CHANNELS-1:0] chan_onehot(input logic [1:0] c);
		chan_onehot = CHANNELS'(1) << c;
	endfunction

	// ****************************************
	// pins, results buffer
	// ****************************************
	pin_sync #(
		.W(PIN_W),
		.RST_VAL(PIN_RST)
	) u_sync (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_pin({i_din, i_sclk, i_cs_n}),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	assign cs_low = ~pin_lvl[PIN_CS];
	assign cs_fall = pin_fall[PIN_CS];
	assign sclk_lvl = pin_lvl[PIN_SCLK];
	assign sclk_rise = pin_rise[PIN_SCLK];
	assign sclk_fall = pin_fall[PIN_SCLK];
	assign din_s = pin_lvl[PIN_DIN];

	// flushed while deselected: a word left from an aborted frame must never leak out
	result_fifo #(
		.W(RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_flush(~cs_low),
		.i_in_valid(st_r.push_vld),
		.o_in_ready(fifo_in_rdy),
		.i_in_data(st_r.code),
		.o_out_valid(fifo_out_vld),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_data)
	);

	assign fifo_pop = cs_low & ~cs_fall & (st_r.mode == MODE_HOLD) & ~st_r.loaded
		& (st_r.bits == 4'h0);
	// a frame whose sclk idles low makes its own first falling edge at select
	assign trk_now = cs_low & (cs_fall ? (~sclk_lvl | sclk_fall) : (sclk_fall
		& ((st_r.fall_cnt == FALL_LAST) | (st_r.fall_cnt == FALL_NONE))));
	assign sh_new = {st_r.ctrl_sh[6:0], din_s};

	// ****************************************
	// frame sequencing
	// ****************************************
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sample = 1'b0;
		if (st_r.push_vld && fifo_in_rdy)
		begin
			st_nxt.push_vld = 1'b0;
		end
		if (!cs_low)
		begin
			st_nxt.mode = MODE_IDLE;
			st_nxt.fall_cnt = FALL_NONE;
			st_nxt.rise_cnt = 4'h0;
			st_nxt.loaded = 1'b0;
			st_nxt.bits = 4'h0;
			st_nxt.dout = 1'b0;
			st_nxt.oe_n = 1'b1;
			st_nxt.push_vld = 1'b0;
		end
		else
		begin
			st_nxt.oe_n = 1'b0;
			if (cs_fall)
			begin
				st_nxt.rise_cnt = 4'h0;
				st_nxt.fall_cnt = FALL_NONE;
				st_nxt.mode = MODE_IDLE;
				st_nxt.bits = 4'h0;
				st_nxt.dout = 1'b0;
			end
			else if (sclk_fall && !trk_now)
			begin
				st_nxt.fall_cnt = 5'(st_r.fall_cnt + 5'h01);
				if (st_nxt.fall_cnt == FALL_HOLD)
				begin
					st_nxt.mode = MODE_HOLD;
					st_nxt.sample = 1'b1;
					st_nxt.push_vld = 1'b1;
					st_nxt.code = i_code;
				end
				if (st_r.bits > 4'h1)
				begin
					st_nxt.shreg = {st_r.shreg[RESULT_W-2:0], 1'b0};
					st_nxt.bits = 4'(st_r.bits - 4'h1);
					st_nxt.dout = st_r.shreg[RESULT_W-1];
				end
				else
				begin
					st_nxt.bits = 4'h0;
					st_nxt.dout = 1'b0;
				end
			end
			if (trk_now)
			begin
				st_nxt.fall_cnt = FALL_FIRST;
				st_nxt.mode = MODE_TRACK;
				st_nxt.mux = chan_onehot(st_r.pend_chan);
				st_nxt.loaded = 1'b0;
				st_nxt.bits = 4'h0;
				st_nxt.dout = 1'b0;
			end
			if (sclk_rise && !cs_fall)
			begin
				st_nxt.rise_cnt = 4'(st_r.rise_cnt + 4'h1);
				if (st_r.rise_cnt < CTRL_BITS)
				begin
					st_nxt.ctrl_sh = sh_new;
				end
				if (st_r.rise_cnt == CTRL_LAST_RISE)
				begin
					st_nxt.pend_chan = {sh_new[CHAN_HI_POS], sh_new[CHAN_LO_POS]};
				end
			end
			if (fifo_pop && fifo_out_vld)
			begin
				st_nxt.shreg = fifo_data;
				// one spare count: the msb leaves on the next falling edge, the fifth
				st_nxt.bits = 4'(RESULT_BITS + 4'h1);
				st_nxt.dout = 1'b0;
				st_nxt.loaded = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			st_r <= '0;
			st_r.mode <= MODE_IDLE;
			st_r.ctrl_sh <= CTRL_RST;
			st_r.pend_chan <= CHAN_RST;
			st_r.mux <= chan_onehot(CHAN_RST);
			st_r.oe_n <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign o_dout = st_r.dout;
	assign o_dout_oe_n = st_r.oe_n;
	assign o_track = (st_r.mode == MODE_TRACK);
	assign o_sample = st_r.sample;
	assign o_mux_sel = st_r.mux;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	track_phase_a: assert property (o_track |-> (st_r.fall_cnt inside {[1:3]}))
		else $error("track outside cycles one to three");
	hold_phase_a: assert property ((st_r.mode == MODE_HOLD) |-> (st_r.fall_cnt inside {[4:16]}))
		else $error("hold outside cycles four to sixteen");
	sample_edge_a: assert property (o_sample |-> ($past(st_r.fall_cnt) == 5'h03
		&& st_r.fall_cnt == 5'h04 && st_r.mode == MODE_HOLD))
		else $error("sample not on fourth falling edge");
	frame_bound_a: assert property (!cs_low |=> (st_r.mode == MODE_IDLE && !o_sample))
		else $error("activity outside frame");
	restart_track_a: assert property ((cs_low && !cs_fall && sclk_fall
		&& st_r.fall_cnt == 5'h10) |=> (o_track && st_r.fall_cnt == 5'h01))
		else $error("next conversion not started after sixteen");
	mux_onehot_a: assert property ($onehot(o_mux_sel))
		else $error("mux select not one-hot");
	din_capture_a: assert property ((cs_low && !cs_fall && sclk_rise
		&& st_r.rise_cnt < 4'h8) |=> (st_r.ctrl_sh[0] == $past(din_s)))
		else $error("control bit not captured");
	chan_pick_a: assert property ((cs_low && !cs_fall && sclk_rise
		&& st_r.rise_cnt == 4'h7) |=> (st_r.pend_chan == $past(st_r.ctrl_sh[3:2])))
		else $error("channel field wrong");
	msb_first_a: assert property ((cs_low && !cs_fall && sclk_fall && !trk_now
		&& st_r.bits == 4'h9) |=> (o_dout == $past(st_r.shreg[7]) && st_r.bits == 4'h8))
		else $error("result msb not driven first");
	result_load_a: assert property ((cs_low && fifo_pop && fifo_out_vld)
		|=> (st_r.shreg == $past(fifo_data) && st_r.bits == 4'h9 && !o_dout))
		else $error("result not loaded behind a zero");
	release_pin_a: assert property (!cs_low |=> o_dout_oe_n)
		else $error("output driven while deselected");
	count_restart_a: assert property (cs_fall |=> (st_r.rise_cnt == 4'h0
		&& st_r.fall_cnt inside {[0:1]}))
		else $error("cycle count not restarted");
	shift_once_a: assert property ((st_r.mode == MODE_HOLD && st_r.bits == 4'h0
		&& st_r.loaded) |-> !o_dout)
		else $error("output not zero after result");

	// ****************************************
	// output timing and sequencing checks
	// ****************************************
	bit_shift_a: assert property ((cs_low && !cs_fall && sclk_fall && !trk_now
		&& st_r.bits > 4'h1) |=> (o_dout == $past(st_r.shreg[7])
		&& st_r.bits == 4'($past(st_r.bits) - 4'h1)))
		else $error("result bit not shifted on falling edge");
	lead_zero_a: assert property (o_track |-> !o_dout)
		else $error("output not zero while tracking");
	pad_zero_a: assert property ((st_r.mode == MODE_HOLD
		&& (st_r.fall_cnt == 5'h04 || st_r.fall_cnt > 5'h0C)) |-> !o_dout)
		else $error("output not zero outside result bits");
	drive_pin_a: assert property (cs_low |=> !o_dout_oe_n)
		else $error("output released inside frame");
	hold_entry_a: assert property ((cs_low && !cs_fall && sclk_fall && !trk_now
		&& st_r.fall_cnt == 5'h03) |=> (o_sample && st_r.mode == MODE_HOLD))
		else $error("fourth falling edge did not sample");
	code_take_a: assert property (o_sample |-> (st_r.code == $past(i_code)))
		else $error("result not taken at sample");
	sample_pulse_a: assert property (o_sample |=> !o_sample)
		else $error("sample pulse longer than one cycle");
	push_once_a: assert property (o_sample |-> st_r.push_vld)
		else $error("sampled result not queued");
	fifo_room_a: assert property (st_r.push_vld |-> fifo_in_rdy)
		else $error("result buffer full");
	track_mux_a: assert property (trk_now
		|=> (o_mux_sel == chan_onehot($past(st_r.pend_chan))))
		else $error("track start did not route pending channel");
	mux_steady_a: assert property (!trk_now |=> $stable(o_mux_sel))
		else $error("mux moved outside track start");
	high_start_a: assert property ((cs_fall && sclk_lvl && !sclk_fall)
		|=> (!o_track && st_r.fall_cnt == 5'h00))
		else $error("track began before first falling edge");
	count_bound_a: assert property (st_r.fall_cnt <= FALL_LAST)
		else $error("falling edge count past sixteen");
endmodule
`default_nettype wire

// ---- sim/host_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host serial master, half period in mclk
// ****************************************
module host_master (
	input wire logic i_mclk,
	input wire logic i_dout,
	input wire logic i_track,
	input wire logic [3:0] i_mux,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_din,
	output logic [7:0] o_code
);
	import adc_frame_pkg::*;
	// slow sclk so the 3 mclk pin path settles before each sample
	localparam int HALF = 8;
	logic [7:0] got [4];
	logic [7:0] pad [4];
	logic [3:0] mux [4];
	logic [1:0] trk [4];
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din = 1'b0;
		o_code = 8'h00;
	end
	task automatic half();
		repeat (HALF) @(posedge i_mclk);
	endtask
	task automatic frame(input int periods, input logic hi, input logic [7:0] ctrl [4],
		input logic [7:0] code [4]);
		int k;
		int c;
		int ph;
		o_sclk <= hi;
		half();
		o_cs_n <= 1'b0;
		// select settles first, so a high idle clock is still high at the start
		half();
		for (k = 0; k < periods; k++)
		begin
			c = (k / 16) % 4;
			ph = k % 16;
			if (k > 0 || hi)
				o_sclk <= 1'b0;
			if (ph == 0)
				o_code <= code[c];
			// don't-care bits toggle so a wrong field pick shows up
			o_din <= (ph < 8) ? ctrl[c][7 - ph] : ~o_din;
			half();
			if (ph == 1)
			begin
				mux[c] = i_mux;
				trk[c][0] = i_track;
			end
			if (ph == 4)
				trk[c][1] = i_track;
			o_sclk <= 1'b1;
			if (ph >= 4 && ph < 12)
				got[c] = {got[c][6:0], i_dout};
			else
				pad[c] = {pad[c][6:0], i_dout};
			half();
		end
		// short frames are cut on purpose to test aborts
		o_sclk <= hi;
		half();
		o_cs_n <= 1'b1;
		half();
		half();
	endtask
endmodule
`default_nettype wire

// ---- sim/test_adc_frame_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_adc_frame_ctrl;
	import adc_frame_pkg::*;
	logic mclk;
	logic srst;
	logic cs_n;
	logic sclk;
	logic din;
	logic [7:0] code;
	logic o_dout;
	logic o_dout_oe_n;
	logic o_track;
	logic o_sample;
	logic [3:0] o_mux_sel;
	logic dout_pin;
	logic [31:0] rnd;
	logic [7:0] ctrl [4];
	logic [7:0] cv [4];
	int n_errors;
	int tests_run;
	int cycles;
	int n_samp;
	int nexp;
	int pend;
	int f;
	int c;
	int plen [8] = '{16, 16, 48, 6, 20, 64, 13, 32};
	// released pin shows the inverse level, never a stale bit
	assign dout_pin = o_dout_oe_n ? ~o_dout : o_dout;
	adc_frame_ctrl i_adc_frame_ctrl (
		.i_mclk(mclk),
		.i_srst(srst),
		.i_cs_n(cs_n),
		.i_sclk(sclk),
		.i_din(din),
		.i_code(code),
		.o_dout(o_dout),
		.o_dout_oe_n(o_dout_oe_n),
		.o_track(o_track),
		.o_sample(o_sample),
		.o_mux_sel(o_mux_sel)
	);
	host_master i_host_master (
		.i_mclk(mclk),
		.i_dout(dout_pin),
		.i_track(o_track),
		.i_mux(o_mux_sel),
		.o_cs_n(cs_n),
		.o_sclk(sclk),
		.o_din(din),
		.o_code(code)
	);
	// ****************************************
	// clock, timeout, helpers
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (o_sample === 1'b1)
			n_samp++;
		if (cycles == 20000)
		begin
			n_errors++;
			results();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic results();
		$display("errors=%0d tests=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************
	// frames of every length kind, both idle levels
	// ****************************************
	initial
	begin
		srst = 1'b1;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		n_samp = 0;
		pend = 0;
		rnd = 32'h95C4AE32;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		check(o_mux_sel, 4'h1);
		check(o_dout_oe_n, 1'b1);
		for (f = 0; f < 8; f++)
		begin
			for (c = 0; c < 4; c++)
			begin
				rnd = lfsr(rnd);
				ctrl[c] = (rnd[7:0] & 8'hE7) | (8'((f + c) % 4) << 3);
				cv[c] = rnd[15:8];
			end
			n_samp = 0;
			nexp = 0;
			i_host_master.frame(plen[f], f[0], ctrl, cv);
			for (c = 0; c < 4; c++)
			begin
				if (plen[f] > 16 * c + 1)
					check(i_host_master.mux[c], 4'h1 << pend);
				if (plen[f] > 16 * c + 3)
					nexp++;
				if (plen[f] > 16 * c + 4)
					check(i_host_master.trk[c], 2'h1);
				if (plen[f] >= 16 * c + 12)
					check(i_host_master.got[c], cv[c]);
				if (plen[f] >= 16 * c + 16)
					check(i_host_master.pad[c], 8'h00);
				if (plen[f] >= 16 * c + 8)
					pend = ctrl[c][4:3];
			end
			check(n_samp, nexp);
			check(o_dout_oe_n, 1'b1);
			check(o_track, 1'b0);
		end
		results();
	end
endmodule
`default_nettype wire
